// File: hdl/cfbm_pkg.sv
// Shared constants, field positions and carrier types of the flag unit.
package cfbm_pkg;

  // Clock rate and the oscillator stabilisation time after a stop wake.
  localparam int unsigned CLK_MHZ   = 125;
  localparam int unsigned T_STAB_NS = 32768;
  localparam int unsigned STAB_CYC  = (T_STAB_NS * CLK_MHZ + 999) / 1000;
  localparam logic [12:0] STAB_CNT  = 13'(STAB_CYC - 1);

  // Bit positions inside the flag byte.
  localparam int unsigned BIT_V = 7;
  localparam int unsigned BIT_H = 4;
  localparam int unsigned BIT_I = 3;
  localparam int unsigned BIT_N = 2;
  localparam int unsigned BIT_Z = 1;
  localparam int unsigned BIT_C = 0;
  localparam logic [7:0]  FLAG_ONES = 8'h60;
  localparam logic [7:0]  FLAG_RST  = 8'h68;

  // Pointer reset values and vectors.
  localparam logic [15:0] SP_RST      = 16'h00FF;
  localparam logic [15:0] VEC_BRK     = 16'hFFFC;
  localparam logic [15:0] VEC_BRK_MON = 16'hFEFC;
  localparam logic [15:0] VEC_IRQ_TOP = 16'hFFFA;
  localparam logic [15:0] PC_STEP     = 16'h0002;

  // Opcodes decoded here and cycle counts of the timed operations.
  localparam logic [7:0]  OPC_AIS = 8'hA7;
  localparam logic [7:0]  OPC_AIX = 8'hAF;
  localparam logic [7:0]  OPC_BCC = 8'h24;
  localparam logic [12:0] CYC_ONE = 13'h0001;
  localparam logic [12:0] CYC_AIS = 13'h0002;
  localparam logic [12:0] CYC_AIX = 13'h0002;
  localparam logic [12:0] CYC_BCC = 13'h0003;

  // Interrupt request lines; line 0 is the external pin and wakes stop.
  localparam int unsigned NIRQ    = 4;
  localparam int unsigned IRQ_EXT = 0;
  localparam logic [2:0]  LAST_STACK_BYTE = 3'h4;
  localparam logic [2:0]  PULL_END        = 3'h5;

  // Register map of the plain register port.
  localparam logic [3:0] A_FLAG = 4'h0;
  localparam logic [3:0] A_SPL  = 4'h1;
  localparam logic [3:0] A_SPH  = 4'h2;
  localparam logic [3:0] A_XL   = 4'h3;
  localparam logic [3:0] A_XH   = 4'h4;
  localparam logic [3:0] A_PCL  = 4'h5;
  localparam logic [3:0] A_PCH  = 4'h6;
  localparam logic [3:0] A_STAT = 4'h7;

  typedef enum logic [4:0] {
    K_NONE, K_ADD, K_ADC, K_SUB, K_AND, K_ASL, K_ASR, K_AIS, K_AIX,
    K_BCC, K_CLI, K_SEI, K_WAIT, K_STOP, K_RTI, K_PUSH_INDEX_HIGH_OP, K_PULL_INDEX_HIGH_OP, K_SWI
  } cfbm_kind_t;

  typedef enum logic [3:0] {
    PH_RUN, PH_PUSH, PH_MASK, PH_VEC, PH_PULL, PH_PULL_INDEX_HIGH_OP,
    PH_WAIT, PH_STOP, PH_STAB
  } cfbm_phase_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] opcode;
    cfbm_kind_t kind;
    logic [7:0] a;
    logic [7:0] m;
  } cfbm_op_t;

  typedef struct packed {
    logic        we;
    logic        re;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } cfbm_stk_t;

endpackage

// File: hdl/cfbm_flag_unit.sv
// Flag byte, interrupt mask and pointer adjust logic of the 8-bit core.
//
// The plain strobed port and the register addresses were decided locally.
`timescale 1ns/10ps
`default_nettype none

// Operation
// - Eight-bit flag byte, bits six, five one.
// - Overflow flag follows two's complement overflow.
// - Half carry from bit three on adds.
// - Mask blocks interrupts; set after stacking.
// - Upper index byte never stacked on entry.
// - Highest-priority pending request is serviced first.
// - Return pulls registers and saved mask.
// - Reset sets mask; only unmask, wait, stop or return clears it.
// - Negative flag copies result bit seven.
// - Zero flag set on zero result.
// - Carry on add carry, borrow, shifts.
// - Wait clears mask, stops clock.
// - Stop clears mask; restart after stabilisation.
// - Break traps through break or monitor vector.
// - Return ends break once request gone.
// - Stack pointer add signed immediate, two cycles.
// - Index add signed immediate, two cycles.
// - Branch when carry clear, three cycles.
// - Push decrements, pull increments stack pointer.
module cfbm_flag_unit
  import cfbm_pkg::*;
(
  input  wire logic              clk_sys,    // Core clock, 125 MHz.
  input  wire logic              rstn,       // Asynchronous reset, low.
  input  wire logic [3:0]        reg_addr,   // Register address.
  input  wire logic [7:0]        reg_wdata,  // Register write data.
  input  wire logic              reg_wr,     // Register write strobe.
  input  wire logic              reg_rd,     // Register read strobe.
  output logic      [7:0]        reg_rdata,  // Read data, next cycle.
  input  wire cfbm_op_t          op_i,       // Operation from decode.
  output logic                   op_ready,   // Operation may be taken.
  output logic                   op_done,    // Operation finished.
  input  wire logic [7:0]        acc_i,      // Accumulator for stacking.
  output logic                   acc_ld,     // Accumulator load pulse.
  output logic      [7:0]        acc_val,    // Accumulator load value.
  input  wire logic [NIRQ-1:0]   irq_req,    // Interrupt requests.
  output logic                   vec_fetch,  // Vector fetch pulse.
  output logic      [15:0]       vec_addr,   // Vector address.
  input  wire logic              brk_en,     // Break support enabled.
  input  wire logic              brk_req,    // Break request level.
  input  wire logic              mon_mode,   // Monitor mode selected.
  output cfbm_stk_t              stk_o,      // Stack memory request.
  input  wire logic [7:0]        stk_rdata,  // Stack data while re high.
  input  wire logic              pc_ld,      // Core loads program count.
  input  wire logic [15:0]       pc_val,     // Value for that load.
  output logic      [7:0]        flag_byte,  // Flag byte.
  output logic      [15:0]       sp_o,       // Stack pointer.
  output logic      [15:0]       hx_o,       // Index register.
  output logic      [15:0]       pc_o,       // Program counter.
  output logic                   cpu_clk_en, // Core clock enable.
  output logic                   in_break    // Break handler active.
);

  typedef struct packed {
    logic [7:0]  flags;
    logic [15:0] sp;
    logic [15:0] hx;
    logic [15:0] pc;
    cfbm_phase_t phase;
    logic [12:0] cnt;
    logic [2:0]  idx;
    logic [15:0] vec;
    logic        in_brk;
    logic        done;
    logic        acc_ld;
    logic [7:0]  acc_val;
    cfbm_stk_t   stk;
    logic        vec_fetch;
    logic [7:0]  rdata;
  } cfbm_st_t;

  localparam cfbm_st_t ST_RST = '{
    flags: FLAG_RST, sp: SP_RST, hx: '0, pc: '0, phase: PH_RUN,
    cnt: '0, idx: '0, vec: '0, in_brk: 1'b0, done: 1'b0, acc_ld: 1'b0,
    acc_val: '0, stk: '0, vec_fetch: 1'b0, rdata: '0};

  cfbm_st_t   st;
  cfbm_st_t   next_st;
  logic       rst_meta_n;
  logic       rst_n_s;
  logic       brk_pend;
  logic       irq_pend;
  logic       take;
  logic       accept;
  cfbm_kind_t kind;
  logic [1:0] prio;
  logic       cin;
  logic [8:0] sum;
  logic [4:0] nib;
  logic [8:0] dif;
  logic [15:0] rel;
  logic [7:0] res;
  logic [12:0] cyc;

  // Opcode decode for the table-defined operations; other kinds come in.
  function automatic cfbm_kind_t decode(input logic [7:0] opc,
                                        input cfbm_kind_t k);
    cfbm_kind_t d;
    d = k;
    if (opc == OPC_AIS) d = K_AIS;
    else if (opc == OPC_AIX) d = K_AIX;
    else if (opc == OPC_BCC) d = K_BCC;
    return d;
  endfunction

  // Lowest request index wins; used for the vector choice only.
  function automatic logic [1:0] pick(input logic [NIRQ-1:0] req);
    logic [1:0] p;
    p = '0;
    for (int i = NIRQ - 1; i >= 0; i--)
    begin
      if (req[i]) p = 2'(i);
    end
    return p;
  endfunction

  // Reset release passes two flops so no flop sees a ragged release.
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_meta_n <= 1'b0;
      rst_n_s    <= 1'b0;
    end
    else
    begin
      rst_meta_n <= 1'b1;
      rst_n_s    <= rst_meta_n;
    end
  end

  // Break traps ignore the mask; maskable requests wait for it to clear.
  assign brk_pend = brk_en && brk_req && !st.in_brk;
  assign irq_pend = |irq_req && !st.flags[BIT_I];
  assign take     = rst_n_s && st.phase == PH_RUN && st.cnt == '0 &&
                    (brk_pend || irq_pend);
  assign op_ready = rst_n_s && st.phase == PH_RUN && st.cnt == '0 && !take;
  assign accept   = op_ready && op_i.valid;
  assign kind     = decode(op_i.opcode, op_i.kind);
  assign prio     = pick(irq_req);

  // Adder, subtractor and sign extension of the operand.
  assign cin = (kind == K_ADC) ? st.flags[BIT_C] : 1'b0;
  assign sum = {1'b0, op_i.a} + {1'b0, op_i.m} + {8'h00, cin};
  assign nib = {1'b0, op_i.a[3:0]} + {1'b0, op_i.m[3:0]} + {4'h0, cin};
  assign dif = {1'b0, op_i.a} - {1'b0, op_i.m};
  assign rel = {{8{op_i.m[7]}}, op_i.m};

  // Next state of the whole block.
  always_comb
  begin
    next_st           = st;
    next_st.done      = 1'b0;
    next_st.acc_ld    = 1'b0;
    next_st.stk.we    = 1'b0;
    next_st.stk.re    = 1'b0;
    next_st.vec_fetch = 1'b0;
    next_st.rdata     = 8'h00;
    res               = 8'h00;
    cyc               = CYC_ONE;
    // Register port; software may set the mask but never clear it.
    if (reg_rd)
    begin
      unique case (reg_addr)
        A_FLAG:  next_st.rdata = st.flags;
        A_SPL:   next_st.rdata = st.sp[7:0];
        A_SPH:   next_st.rdata = st.sp[15:8];
        A_XL:    next_st.rdata = st.hx[7:0];
        A_XH:    next_st.rdata = st.hx[15:8];
        A_PCL:   next_st.rdata = st.pc[7:0];
        A_PCH:   next_st.rdata = st.pc[15:8];
        A_STAT:  next_st.rdata = {3'h0, st.in_brk, st.phase};
        default: next_st.rdata = 8'h00;
      endcase
    end
    if (reg_wr)
    begin
      unique case (reg_addr)
        A_FLAG:
        begin
          next_st.flags = reg_wdata | FLAG_ONES;
          next_st.flags[BIT_I] = st.flags[BIT_I] | reg_wdata[BIT_I];
        end
        A_SPL:   next_st.sp[7:0]  = reg_wdata;
        A_SPH:   next_st.sp[15:8] = reg_wdata;
        A_XL:    next_st.hx[7:0]  = reg_wdata;
        A_XH:    next_st.hx[15:8] = reg_wdata;
        A_PCL:   next_st.pc[7:0]  = reg_wdata;
        A_PCH:   next_st.pc[15:8] = reg_wdata;
        default: ;
      endcase
    end
    if (pc_ld) next_st.pc = pc_val;
    unique case (st.phase)
      PH_RUN:
      begin
        if (st.cnt != '0)
        begin
          next_st.cnt  = st.cnt - CYC_ONE;
          next_st.done = (st.cnt == CYC_ONE);
        end
        if (take)
        begin
          // Entry stacks PC, X, A and flags; upper index stays put.
          next_st.phase = PH_PUSH;
          next_st.idx   = '0;
          next_st.in_brk = st.in_brk | brk_pend;
          if (brk_pend)
            next_st.vec = mon_mode ? VEC_BRK_MON : VEC_BRK;
          else
            next_st.vec = VEC_IRQ_TOP - {13'h0000, prio, 1'b0};
        end
        else if (accept)
        begin
          // Flags not named below are left as they were.
          unique case (kind)
            K_ADD, K_ADC:
            begin
              res = sum[7:0];
              next_st.flags[BIT_H] = nib[4];
              next_st.flags[BIT_C] = sum[8];
              next_st.flags[BIT_V] = (op_i.a[7] == op_i.m[7]) &&
                                     (res[7] != op_i.a[7]);
            end
            K_SUB:
            begin
              res = dif[7:0];
              next_st.flags[BIT_C] = dif[8];
              next_st.flags[BIT_V] = (op_i.a[7] != op_i.m[7]) &&
                                     (res[7] != op_i.a[7]);
            end
            K_AND:
            begin
              res = op_i.a & op_i.m;
              next_st.flags[BIT_V] = 1'b0;
            end
            K_ASL:
            begin
              res = {op_i.a[6:0], 1'b0};
              next_st.flags[BIT_C] = op_i.a[7];
              next_st.flags[BIT_V] = res[7] ^ op_i.a[7];
            end
            K_ASR:
            begin
              res = {op_i.a[7], op_i.a[7:1]};
              next_st.flags[BIT_C] = op_i.a[0];
              next_st.flags[BIT_V] = res[7] ^ op_i.a[0];
            end
            K_AIS:
            begin
              next_st.sp = st.sp + rel;
              cyc = CYC_AIS;
            end
            K_AIX:
            begin
              next_st.hx = st.hx + rel;
              cyc = CYC_AIX;
            end
            K_BCC:
            begin
              next_st.pc = st.pc + PC_STEP;
              if (!st.flags[BIT_C]) next_st.pc = st.pc + PC_STEP + rel;
              cyc = CYC_BCC;
            end
            K_CLI:  next_st.flags[BIT_I] = 1'b0;
            K_SEI:  next_st.flags[BIT_I] = 1'b1;
            K_WAIT:
            begin
              next_st.flags[BIT_I] = 1'b0;
              next_st.phase = PH_WAIT;
            end
            K_STOP:
            begin
              next_st.flags[BIT_I] = 1'b0;
              next_st.phase = PH_STOP;
            end
            K_RTI:
            begin
              next_st.phase = PH_PULL;
              next_st.idx   = '0;
            end
            K_PUSH_INDEX_HIGH_OP:
            begin
              next_st.stk.we    = 1'b1;
              next_st.stk.addr  = st.sp;
              next_st.stk.wdata = st.hx[15:8];
              next_st.sp        = st.sp - 16'h0001;
            end
            K_PULL_INDEX_HIGH_OP:
            begin
              next_st.phase = PH_PULL_INDEX_HIGH_OP;
              next_st.idx   = '0;
            end
            K_SWI:
            begin
              next_st.phase = PH_PUSH;
              next_st.idx   = '0;
              next_st.vec   = VEC_BRK;
            end
            default: ;
          endcase
          if (kind inside {K_ADD, K_ADC, K_SUB, K_AND, K_ASL, K_ASR})
          begin
            next_st.flags[BIT_N] = res[7];
            next_st.flags[BIT_Z] = (res == 8'h00);
            next_st.acc_ld  = 1'b1;
            next_st.acc_val = res;
          end
          if (kind inside {K_NONE, K_ADD, K_ADC, K_SUB, K_AND, K_ASL,
                           K_ASR, K_AIS, K_AIX, K_BCC, K_CLI, K_SEI,
                           K_PUSH_INDEX_HIGH_OP})
          begin
            next_st.cnt  = cyc - CYC_ONE;
            next_st.done = (cyc == CYC_ONE);
          end
        end
      end
      PH_PUSH:
      begin
        // Return address low first, flag byte last, pointer going down.
        next_st.stk.we   = 1'b1;
        next_st.stk.addr = st.sp;
        next_st.sp       = st.sp - 16'h0001;
        unique case (st.idx)
          3'h0:    next_st.stk.wdata = st.pc[7:0];
          3'h1:    next_st.stk.wdata = st.pc[15:8];
          3'h2:    next_st.stk.wdata = st.hx[7:0];
          3'h3:    next_st.stk.wdata = acc_i;
          default: next_st.stk.wdata = st.flags;
        endcase
        next_st.idx = st.idx + 3'h1;
        if (st.idx == LAST_STACK_BYTE) next_st.phase = PH_MASK;
      end
      PH_MASK:
      begin
        // Mask goes up only once the frame is on the stack.
        next_st.flags[BIT_I] = 1'b1;
        next_st.phase = PH_VEC;
      end
      PH_VEC:
      begin
        next_st.vec_fetch = 1'b1;
        next_st.phase     = PH_RUN;
      end
      PH_PULL:
      begin
        // Data is valid while the registered read strobe is high.
        if (st.idx != PULL_END)
        begin
          next_st.stk.re   = 1'b1;
          next_st.stk.addr = st.sp + 16'h0001;
          next_st.sp       = st.sp + 16'h0001;
        end
        if (st.stk.re)
        begin
          unique case (st.idx)
            3'h1:
              next_st.flags = stk_rdata | FLAG_ONES;
            3'h2:
            begin
              next_st.acc_ld  = 1'b1;
              next_st.acc_val = stk_rdata;
            end
            3'h3:    next_st.hx[7:0]  = stk_rdata;
            3'h4:    next_st.pc[15:8] = stk_rdata;
            default: next_st.pc[7:0]  = stk_rdata;
          endcase
        end
        next_st.idx = st.idx + 3'h1;
        if (st.idx == PULL_END)
        begin
          next_st.idx   = '0;
          next_st.phase = PH_RUN;
          next_st.done  = 1'b1;
          if (!brk_req) next_st.in_brk = 1'b0;
        end
      end
      PH_PULL_INDEX_HIGH_OP:
      begin
        next_st.idx = st.idx + 3'h1;
        if (st.idx == 3'h0)
        begin
          next_st.stk.re   = 1'b1;
          next_st.stk.addr = st.sp + 16'h0001;
          next_st.sp       = st.sp + 16'h0001;
        end
        else
        begin
          next_st.hx[15:8] = stk_rdata;
          next_st.phase    = PH_RUN;
          next_st.done     = 1'b1;
        end
      end
      PH_WAIT:
      begin
        // Any request wakes; the mask stays clear for its service.
        if (|irq_req)
        begin
          next_st.phase = PH_RUN;
          next_st.done  = 1'b1;
        end
      end
      PH_STOP:
      begin
        if (irq_req[IRQ_EXT])
        begin
          next_st.phase = PH_STAB;
          next_st.cnt   = STAB_CNT;
        end
      end
      PH_STAB:
      begin
        // Oscillator settles before the core clock runs again; the count
        // stops at zero so that the run phase is not left looking busy.
        if (st.cnt == '0)
        begin
          next_st.phase = PH_RUN;
          next_st.done  = 1'b1;
        end
        else
          next_st.cnt = st.cnt - CYC_ONE;
      end
    endcase
  end

  // Every reset sets the mask; a wake from low power leaves it clear.
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      st <= ST_RST;
    else if (!rst_n_s)
      st <= ST_RST;
    else
      st <= next_st;
  end

  assign reg_rdata  = st.rdata;
  assign op_done    = st.done;
  assign acc_ld     = st.acc_ld;
  assign acc_val    = st.acc_val;
  assign vec_fetch  = st.vec_fetch;
  assign vec_addr   = st.vec;
  assign stk_o      = st.stk;
  assign flag_byte  = st.flags;
  assign sp_o       = st.sp;
  assign hx_o       = st.hx;
  assign pc_o       = st.pc;
  assign in_break   = st.in_brk;
  assign cpu_clk_en = !(st.phase inside {PH_WAIT, PH_STOP, PH_STAB});

  // Checks on flag results, entry order and timed operations.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n_s);

  AST_ONES: assert property (flag_byte[6:5] == 2'b11)
    else $error("Fixed flag bits not one.");
  AST_OVF: assert property (accept && kind == K_ADD |=> flag_byte[BIT_V] ==
    (($past(op_i.a[7]) == $past(op_i.m[7])) &&
     (acc_val[7] != $past(op_i.a[7]))))
    else $error("Overflow flag wrong after add.");
  AST_HALF: assert property (accept && kind inside {K_ADD, K_ADC} |=>
    flag_byte[BIT_H] == $past(nib[4]))
    else $error("Half carry wrong after add.");
  AST_MASK_ORDER: assert property (stk_o.we && st.phase == PH_MASK |=>
    flag_byte[BIT_I] ##1 vec_fetch)
    else $error("Mask not set between stacking and vector fetch.");
  AST_NO_MASKED: assert property (flag_byte[BIT_I] && !(brk_en && brk_req)
    && st.phase == PH_RUN && !(accept && kind == K_SWI) |=>
    st.phase != PH_PUSH)
    else $error("Masked request was taken.");
  AST_NZ: assert property (acc_ld && st.phase == PH_RUN |->
    flag_byte[BIT_Z] == (acc_val == 8'h00) &&
    flag_byte[BIT_N] == acc_val[7])
    else $error("Zero or negative flag disagrees with result.");
  AST_CLEAR_CAUSE: assert property ($fell(flag_byte[BIT_I]) |->
    $past(accept && kind inside {K_CLI, K_WAIT, K_STOP}) ||
    $past(st.phase == PH_PULL))
    else $error("Mask cleared without a clearing operation.");
  AST_AIS: assert property (accept && kind == K_AIS |=>
    sp_o == $past(st.sp) + $past(rel) && $stable(flag_byte) ##1
    op_done)
    else $error("Stack pointer add wrong.");
  AST_BCC: assert property (accept && kind == K_BCC && !pc_ld &&
    !flag_byte[BIT_C] |=> pc_o == $past(st.pc) + PC_STEP + $past(rel)
    ##1 !op_done ##1 op_done)
    else $error("Branch on carry clear wrong.");
  AST_PUSH_SP: assert property (stk_o.we |-> sp_o ==
    stk_o.addr - 16'h0001)
    else $error("Push did not decrement stack pointer.");
  AST_STAB: assert property (st.phase == PH_STOP && irq_req[IRQ_EXT] |=>
    !cpu_clk_en [*8])
    else $error("Clock restarted before stabilisation.");
  AST_WAIT: assert property (accept && kind == K_WAIT |=>
    !flag_byte[BIT_I] && !cpu_clk_en)
    else $error("Wait did not clear mask and stop clock.");

  COV_IRQ: cover property (take && !brk_pend ##[1:12] vec_fetch);
  COV_BRK: cover property (take && brk_pend ##[1:12] vec_fetch);
  COV_RTI: cover property (accept && kind == K_RTI ##[1:8] op_done);
  COV_STOP: cover property (st.phase == PH_STAB ##1 st.phase == PH_STAB);

endmodule

`default_nettype wire

// File: dv/cfbm_tb.sv
// Self-checking bench of the flag byte and mask unit.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
  failures++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module testbench;
  import cfbm_pkg::*;
  logic        clk_sys, rstn, reg_wr, reg_rd, pc_ld, rd_pend;
  logic        brk_en, brk_req, mon_mode, in_break;
  logic [7:0]  er;
  logic [3:0]  reg_addr, irq_req;
  logic [7:0]  reg_wdata, reg_rdata, acc_i, stk_rdata, flag_byte, fl, a, m;
  logic [15:0] pc_val, vec_addr, sp_o, hx_o, pc_o, sp, hx;
  logic        op_ready, op_done, vec_fetch, cpu_clk_en;
  logic [56:0] nt;
  logic [31:0] nv;
  cfbm_op_t    op_i;
  cfbm_stk_t   stk_o;
  cfbm_kind_t  k;
  logic [7:0]  mem [256];
  logic [56:0] q_op [$];
  logic [7:0]  q_rd [$];
  logic [31:0] q_vec [$];
  cfbm_kind_t  kinds [6] = '{K_ADD, K_ADC, K_SUB, K_AND, K_ASL, K_ASR};
  int          failures = 0;
  int          n_checks = 0;

  cfbm_flag_unit u_cfbm_flag_unit (.clk_sys(clk_sys), .rstn(rstn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .op_i(op_i),
    .op_ready(op_ready), .op_done(op_done), .acc_i(acc_i), .acc_ld(),
    .acc_val(), .irq_req(irq_req), .vec_fetch(vec_fetch),
    .vec_addr(vec_addr), .brk_en(brk_en), .brk_req(brk_req),
    .mon_mode(mon_mode),
    .stk_o(stk_o), .stk_rdata(stk_rdata), .pc_ld(pc_ld), .pc_val(pc_val),
    .flag_byte(flag_byte), .sp_o(sp_o), .hx_o(hx_o), .pc_o(pc_o),
    .cpu_clk_en(cpu_clk_en), .in_break(in_break));

  // Free-running core clock, 8 ns period.
  initial
  begin
    clk_sys = 1'h0;
    forever #4 clk_sys = ~clk_sys;
  end

  // Stack memory; data off the read cycle is inverted so stale use shows.
  always @(posedge clk_sys) if (stk_o.we) mem[stk_o.addr[7:0]] <= stk_o.wdata;
  assign stk_rdata = stk_o.re ? mem[stk_o.addr[7:0]] : ~mem[stk_o.addr[7:0]];

  // Result watcher: each appearing result takes the oldest note.
  always @(posedge clk_sys)
  begin
    if (rd_pend)
    begin
      er = q_rd.pop_front();
      `CHK("reg_rdata", er, reg_rdata)
    end
    rd_pend <= reg_rd;
    if (op_done)
    begin
      nt = q_op.pop_front();
      `CHK("flags", nt[55:48], flag_byte)
      `CHK("sp", nt[47:32], sp_o)
      `CHK("hx", nt[31:16], hx_o)
      if (nt[56])
        `CHK("pc", nt[15:0], pc_o)
    end
    if (vec_fetch)
    begin
      nv = q_vec.pop_front();
      `CHK("vec_addr", nv[31:16], vec_addr)
      `CHK("sp_stacked", nv[15:0], sp_o)
      `CHK("mask", 1'h1, flag_byte[BIT_I])
    end
  end

  // Flag model of the bench; unaffected flags keep their value.
  function automatic logic [7:0] alu(cfbm_kind_t k, logic [7:0] a, m, f);
    logic [8:0] r;
    logic [4:0] hs;
    logic       ci;
    ci = (k == K_ADC) & f[BIT_C];
    hs = {1'h0, a[3:0]} + {1'h0, m[3:0]} + {4'h0, ci};
    r = (k == K_SUB) ? {1'h0, a} - {1'h0, m} : {1'h0, a} + {1'h0, m} + ci;
    case (k)
      K_AND: r = {f[BIT_C], a & m};
      K_ASL: r = {a[7], a[6:0], 1'h0};
      K_ASR: r = {a[0], a[7], a[7:1]};
      default: ;
    endcase
    f[BIT_N] = r[7];
    f[BIT_Z] = (r[7:0] == 8'h00);
    f[BIT_C] = r[8];
    if (k == K_ADD || k == K_ADC)
      f[BIT_H] = hs[4];
    if (k == K_AND)
      f[BIT_V] = 1'h0;
    else if (k == K_ASL || k == K_ASR)
      f[BIT_V] = r[7] ^ r[8];
    else
      f[BIT_V] = ((k == K_SUB) ^ (a[7] == m[7])) && (r[7] != a[7]);
    return f;
  endfunction

  task automatic rd(logic [3:0] ad, logic [7:0] e);
    @(posedge clk_sys);
    reg_rd <= 1'h1;
    reg_addr <= ad;
    q_rd.push_back(e);
    @(posedge clk_sys);
    reg_rd <= 1'h0;
  endtask

  task automatic op(cfbm_kind_t kd, logic [7:0] c, a, m);
    int n;
    n = 0;
    @(posedge clk_sys);
    op_i <= '{1'h1, c, kd, a, m};
    acc_i <= a;
    @(negedge clk_sys);
    while (!op_ready && n < 9000)
    begin
      n++;
      @(negedge clk_sys);
    end
    @(posedge clk_sys);
    op_i.valid <= 1'h0;
  endtask

  task automatic rst();
    rstn <= 1'h0;
    repeat (4) @(posedge clk_sys);
    rstn <= 1'h1;
    repeat (4) @(posedge clk_sys);
    fl = 8'h68;
    sp = 16'h00FF;
    hx = 16'h0000;
  endtask

  task automatic note(logic c, logic [15:0] p);
    q_op.push_back({c, fl, sp, hx, p});
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Watchdog: the whole sequence needs well under this span.
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    failures++;
    final_report();
  end

  // Main sequence.
  initial
  begin
    {rstn, reg_wr, reg_rd, pc_ld, reg_addr, reg_wdata, irq_req} = '0;
    {acc_i, pc_val, brk_en, brk_req, mon_mode} = '0;
    op_i = '0;
    void'($urandom(22591));
    rst();
    rd(A_FLAG, 8'h68);
    @(posedge clk_sys);
    {reg_wr, reg_addr, reg_wdata} <= {1'h1, A_FLAG, 8'h00};
    @(posedge clk_sys);
    reg_wr <= 1'h0;
    rd(A_FLAG, 8'h68);
    rd(4'hC, 8'h00);
    fl[BIT_I] = 1'h0;
    note(1'h0, 16'h0);
    op(K_CLI, 8'h00, 8'h00, 8'h00);
    repeat (24)
    begin
      k = kinds[$urandom_range(5)];
      a = 8'($urandom);
      m = 8'($urandom);
      fl = alu(k, a, m, fl);
      note(1'h0, 16'h0);
      op(k, 8'h00, a, m);
    end
    @(posedge clk_sys);
    irq_req <= 4'h6;
    q_vec.push_back({VEC_IRQ_TOP - 16'h0002, sp - 16'h0005});
    repeat (40) @(posedge clk_sys);
    irq_req <= 4'h0;
    note(1'h0, 16'h0);
    op(K_RTI, 8'h00, 8'h00, 8'h00);
    // Break in monitor mode traps through the alternate vector.
    {brk_en, brk_req, mon_mode} <= 3'h7;
    q_vec.push_back({VEC_BRK_MON, sp - 16'h0005});
    repeat (20) @(posedge clk_sys);
    `CHK("in_break", 1'h1, in_break)
    brk_req <= 1'h0;
    note(1'h0, 16'h0);
    op(K_RTI, 8'h00, 8'h00, 8'h00);
    a = 8'($urandom);
    // Operand 0x80 sign-extends to minus 128.
    sp = sp + 16'hFF80;
    note(1'h0, 16'h0);
    op(K_NONE, OPC_AIS, 8'h00, 8'h80);
    `CHK("in_break", 1'h0, in_break)
    hx = hx + {{8{a[7]}}, a};
    note(1'h0, 16'h0);
    op(K_NONE, OPC_AIX, 8'h00, a);
    for (int i = 0; i < 2; i++)
    begin
      fl = alu(K_SUB, 8'h00, 8'(i), fl);
      note(1'h0, 16'h0);
      op(K_SUB, 8'h00, 8'h00, 8'(i));
      @(posedge clk_sys);
      {pc_ld, pc_val} <= {1'h1, 16'h1234};
      @(posedge clk_sys);
      pc_ld <= 1'h0;
      m = 8'($urandom);
      note(1'h1, 16'h1236 + (i == 0 ? {{8{m[7]}}, m} : 16'h0000));
      op(K_NONE, OPC_BCC, 8'h00, m);
    end
    op(K_WAIT, 8'h00, 8'h00, 8'h00);
    repeat (3) @(posedge clk_sys);
    `CHK("clk_en", 1'h0, cpu_clk_en)
    `CHK("mask", 1'h0, flag_byte[BIT_I])
    // A request wakes the core with the mask still clear, then is serviced.
    note(1'h0, 16'h0);
    q_vec.push_back({VEC_IRQ_TOP, sp - 16'h0005});
    irq_req <= 4'h1;
    repeat (20) @(posedge clk_sys);
    irq_req <= 4'h0;
    sp = sp - 16'h0005;
    // Stop wakes on the external line only after the settling time.
    note(1'h0, 16'h0);
    q_vec.push_back({VEC_IRQ_TOP, sp - 16'h0005});
    op(K_STOP, 8'h00, 8'h00, 8'h00);
    irq_req <= 4'h1;
    repeat (4000) @(posedge clk_sys);
    `CHK("clk_en", 1'h0, cpu_clk_en)
    repeat (120) @(posedge clk_sys);
    irq_req <= 4'h0;
    rst();
    rd(A_FLAG, 8'h68);
    `CHK("clk_en", 1'h1, cpu_clk_en)
    repeat (4) @(posedge clk_sys);
    final_report();
  end
endmodule
`default_nettype wire
